// >>> hw/vdt_top.sv
// Display timing and pixel output of a video port, with its data FIFO
// Assumes a 40 MHz CLK and a link clock slower than CLK / 4
`timescale 1ns/1ps
`include "vdt_defs.svh"

module vdt_fifo #(
  parameter int WIDTH = `VDT_WORD_W,
  parameter int DEPTH = `VDT_DEPTH
) (
  input  wire logic                       clk,       // Clock
  input  wire logic                       arst_n,    // Async reset
  input  wire logic                       in_valid,  // Word offered
  output logic                            in_ready,  // Room left
  input  wire logic [WIDTH-1:0]           in_data,   // Word in
  output logic                            out_valid, // Word held
  input  wire logic                       out_ready, // Word taken
  output logic [WIDTH-1:0]                out_data,  // Word out
  output logic [$clog2(DEPTH):0]          count      // Fill level
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wp_r;
  logic [AW:0]      rp_r;

  // Fill level and flags
  assign count     = wp_r - rp_r;
  assign in_ready  = count != (AW+1)'(DEPTH);
  assign out_valid = count != '0;
  assign out_data  = mem[rp_r[AW-1:0]];

  // Storage
  always_ff @(posedge clk) begin
    if (in_valid && in_ready) mem[wp_r[AW-1:0]] <= in_data;
  end

  // Pointers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      if (in_valid && in_ready) wp_r <= wp_r + 1'b1;
      if (out_valid && out_ready) rp_r <= rp_r + 1'b1;
    end
  end
endmodule

module vdt_top
  import vdt_pkg::*;
(
  input  wire logic                 CLK,         // 40 MHz clock
  input  wire logic                 ARST_N,      // Async reset
  input  wire logic                 ENABLE,      // Display on
  input  wire logic                 UND_RECOVER, // Leave underrun
  input  wire logic                 CMP_ACK,     // Ack complete
  input  wire vdt_vid_t             CFG_V,       // Video config
  input  wire vdt_htim_t            CFG_H,       // Line timing
  input  wire vdt_ftim_t            CFG_F1,      // Field one
  input  wire vdt_ftim_t            CFG_F2,      // Field two
  input  wire logic [3:0]           THRESHOLD,   // DMA words
  input  wire logic [4:0]           INT_MASK,    // Event enables
  input  wire logic                 VCLK_IN,     // Link clock pin
  output logic                      PIX_CLK_OUT, // Pixel clock out
  input  wire logic [2:0]           CTL_I,       // Control pins in
  output logic [2:0]                CTL_O,       // Control pins out
  output logic [2:0]                CTL_OE,      // Pin enables
  output logic [`VDT_PIX_W-1:0]     VDATA,       // Pixel data
  output logic                      DMA_REQ,     // Refill request
  input  wire logic                 DIN_VALID,   // Word offered
  input  wire logic [`VDT_WORD_W-1:0] DIN,       // Word in
  output logic                      DIN_READY,   // FIFO room
  output vdt_evt_t                  EVENTS,      // Event pulses
  output logic                      INT_OUT,     // Global interrupt
  output logic                      FIELD_ID,    // Current field
  output logic                      STALLED      // In underrun
);
  logic [2:0]  vclk_r;
  logic [2:0]  ctl_m_r, ctl_s_r, ctl_d_r;
  logic [3:0]  div_r;
  logic [15:0] h_r, v_r;
  logic        field_r, hsync_r, hblank_r, vsync_r, vblank_r, fld_r;
  logic [2:0]  ctl_o_r;
  vdt_state_t  st_r, st_nxt;
  logic [63:0] word_r;
  logic        have_r, dup_r, img_r, pend_r, req_r, int_r;
  logic [2:0]  idx_r;
  logic [9:0]  chist_r [2];
  logic [4:0]  outst_r;
  logic [`VDT_PIX_W-1:0] vdata_r, pix_val;
  vdt_evt_t    ev, ev_r;
  vdt_ftim_t   f;
  logic        fo_valid;
  logic [63:0] fo_data;
  logic [3:0]  fcnt;

  // Pixel-line match at a programmed position
  function automatic logic at(logic [15:0] h, logic [15:0] v,
                              logic [15:0] x, logic [15:0] y);
    at = (h == x) && (v == y);
  endfunction

  // Clamp a ten-bit sample to eight-bit bounds
  function automatic logic [9:0] clip(logic [9:0] s, logic [7:0] lo,
                                      logic [7:0] hi);
    if (s < {lo, 2'b00}) clip = {lo, 2'b00};
    else if (s > {hi, 2'b11}) clip = {hi, 2'b11};
    else clip = s;
  endfunction

  // Ten-bit sample k of a buffer word
  function automatic logic [9:0] samp(logic [63:0] w, logic [2:0] k,
                                      logic ten, logic dense);
    logic [63:0] t;
    t = w >> (7'(k) * 7'(`VDT_NORM_W));
    if (!ten) t = w >> {k, 3'b000};
    else if (dense && k > 3'd2)
      t = w >> (7'(`VDT_LANE_W) + 7'(k - 3'd3) * 7'(`VDT_DENSE_W));
    else if (dense) t = w >> (7'(k) * 7'(`VDT_DENSE_W));
    samp = ten ? t[9:0] : {t[7:0], 2'b00};
  endfunction

  // Index of the last unit held in one word
  function automatic logic [2:0] last_unit(vdt_vid_t c);
    logic [3:0] s;
    s = !c.mode[0] ? 4'h8 : (c.ten_bit_packing_select ? 4'h6 : 4'h4);
    if (c.mode[1] && c.rgb_unpack_enable) last_unit = 3'h1;
    else if (c.mode[1]) last_unit = 3'(s - 4'h1);
    else last_unit = 3'(s[3:1] - 3'h1);
  endfunction

  wire ext    = CFG_V.external_timing_enable;
  wire raw    = CFG_V.mode[1];
  wire pix_en = vclk_r[1] & ~vclk_r[2];
  wire [2:0] rise = ctl_s_r & ~ctl_d_r;
  wire div_hit = (div_r + 4'h1) >= CFG_V.pixel_count_divider;
  wire adv   = pix_en && (!raw || div_hit);
  wire h_end = h_r == CFG_H.frame_width - 16'h1;
  wire v_end = v_r == CFG_V.frame_height - 16'h1;
  wire blank = hblank_r || vblank_r;
  assign f = field_r ? CFG_F2 : CFG_F1;

  //------------------------------------------------------------------
  // Link sampling
  //------------------------------------------------------------------
  // Two-stage synchronisers, third stage for edge detection
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      vclk_r  <= '0;
      ctl_m_r <= '0;
      ctl_s_r <= '0;
      ctl_d_r <= '0;
    end else begin
      vclk_r  <= {vclk_r[1:0], VCLK_IN};
      ctl_m_r <= CTL_I;
      ctl_s_r <= ctl_m_r;
      ctl_d_r <= ctl_s_r;
    end
  end
  assign PIX_CLK_OUT = vclk_r[2];

  //------------------------------------------------------------------
  // Frame counters
  //------------------------------------------------------------------
  // Raw mode advance divider
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) div_r <= '0;
    else if (pix_en) div_r <= (!raw || div_hit) ? 4'h0 : div_r + 4'h1;
  end

  // Pixel, line and field, resynchronised by pins as slave
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      h_r     <= `VDT_RST_CNT;
      v_r     <= `VDT_RST_CNT;
      field_r <= `VDT_RST_BIT;
    end else if (ext && (rise[0] || rise[1])) begin
      if (rise[0]) h_r <= CFG_H.hs_start;
      if (rise[1]) v_r <= ctl_s_r[2] ? CFG_F2.vs_y0 : CFG_F1.vs_y0;
      field_r <= ctl_s_r[2];
    end else if (adv) begin
      h_r <= h_end ? 16'h0 : h_r + 16'h1;
      if (h_end) begin
        v_r <= v_end ? 16'h0 : v_r + 16'h1;
        // As slave the field follows pin three, not the wrap
        if (v_end && !ext) field_r <= ~field_r;
      end
    end
  end

  //------------------------------------------------------------------
  // Sync, blank and field identity
  //------------------------------------------------------------------
  // Set and clear at programmed positions
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      hsync_r  <= `VDT_RST_BIT;
      hblank_r <= `VDT_RST_BIT;
      vsync_r  <= `VDT_RST_BIT;
      vblank_r <= `VDT_RST_BIT;
      fld_r    <= `VDT_RST_BIT;
    end else if (adv) begin
      if (h_r == CFG_H.hs_start) hsync_r <= 1'b1;
      else if (h_r == CFG_H.hs_stop) hsync_r <= 1'b0;
      if (h_r == CFG_H.hb_start) hblank_r <= 1'b1;
      else if (h_r == CFG_H.hb_stop) hblank_r <= 1'b0;
      if (at(h_r, v_r, f.vs_x0, f.vs_y0)) vsync_r <= 1'b1;
      else if (at(h_r, v_r, f.vs_x1, f.vs_y1)) vsync_r <= 1'b0;
      if (at(h_r, v_r, f.vb_x0, f.vb_y0)) vblank_r <= 1'b1;
      else if (at(h_r, v_r, f.vb_x1, f.vb_y1)) vblank_r <= 1'b0;
      // Each field's position acts only inside that field
      if (!field_r && at(h_r, v_r, CFG_F1.fld_x, CFG_F1.fld_y))
        fld_r <= 1'b0;
      else if (field_r && at(h_r, v_r, CFG_F2.fld_x, CFG_F2.fld_y))
        fld_r <= 1'b1;
    end
  end

  // Control pin selection, registered
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) ctl_o_r <= '0;
    else begin
      case (CFG_V.sel1)
        VDT_C1_HSYNC:  ctl_o_r[0] <= hsync_r;
        VDT_C1_HBLANK: ctl_o_r[0] <= hblank_r;
        VDT_C1_ACTIVE: ctl_o_r[0] <= !blank;
        default:       ctl_o_r[0] <= fld_r;
      endcase
      case (CFG_V.sel2)
        VDT_C2_VSYNC:     ctl_o_r[1] <= vsync_r;
        VDT_C2_VBLANK:    ctl_o_r[1] <= vblank_r;
        VDT_C2_COMPOSITE: ctl_o_r[1] <= hsync_r | vsync_r;
        default:          ctl_o_r[1] <= fld_r;
      endcase
      ctl_o_r[2] <= (CFG_V.sel3 == VDT_C3_FIELD) ? fld_r : blank;
    end
  end
  assign CTL_O  = ctl_o_r;
  assign CTL_OE = {3{~ext}};

  //------------------------------------------------------------------
  // Image window
  //------------------------------------------------------------------
  // Signed window bounds from end of blanking
  logic signed [17:0] x0, y0, hs, vs;
  logic in_win;
  assign x0 = $signed({2'b00, CFG_H.hb_stop}) +
              $signed({{2{f.img_hoff[15]}}, f.img_hoff});
  assign y0 = $signed({2'b00, f.vb_y1}) +
              $signed({{2{f.img_voff[15]}}, f.img_voff});
  assign hs = $signed({2'b00, h_r});
  assign vs = $signed({2'b00, v_r});
  assign in_win = hs >= x0 && hs < x0 + $signed({2'b00, f.img_w}) &&
                  vs >= y0 && vs < y0 + $signed({2'b00, f.img_h});

  //------------------------------------------------------------------
  // Run control
  //------------------------------------------------------------------
  wire want  = adv && st_r == ST_RUN && in_win && !dup_r;
  wire take  = want && have_r;
  wire under = want && !have_r;
  wire fdone = adv && h_end && v_end;

  // Next state
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      ST_WAIT: if (ENABLE && fdone) st_nxt = ST_RUN;
      ST_RUN:  if (!ENABLE) st_nxt = ST_WAIT;
               else if (under) st_nxt = ST_UND;
      ST_UND:  if (UND_RECOVER) st_nxt = ST_WAIT;
      default: st_nxt = ST_WAIT;
    endcase
  end

  // State register
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) st_r <= ST_WAIT;
    else st_r <= st_nxt;
  end
  assign STALLED = st_r == ST_UND;

  //------------------------------------------------------------------
  // Buffer and unpacking
  //------------------------------------------------------------------
  vdt_fifo #(.WIDTH(`VDT_WORD_W), .DEPTH(`VDT_DEPTH)) u_fifo (
    .clk       (CLK),
    .arst_n    (ARST_N),
    .in_valid  (DIN_VALID),
    .in_ready  (DIN_READY),
    .in_data   (DIN),
    .out_valid (fo_valid),
    .out_ready (!have_r),
    .out_data  (fo_data),
    .count     (fcnt)
  );

  // Current word and unit index
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      word_r <= '0;
      have_r <= 1'b0;
      idx_r  <= '0;
    end else if (fo_valid && !have_r) begin
      word_r <= fo_data;
      have_r <= 1'b1;
      idx_r  <= '0;
    end else if (take) begin
      if (idx_r == last_unit(CFG_V)) have_r <= 1'b0;
      idx_r <= idx_r + 3'h1;
    end
  end

  // Scaling repeat flag
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) dup_r <= 1'b0;
    else if (adv)
      dup_r <= CFG_V.scale && in_win && st_r == ST_RUN && !dup_r;
  end

  // Unit extraction
  logic [9:0]  y_s, c_s, c_f;
  logic [31:0] lane;
  always_comb begin
    y_s  = samp(word_r, {idx_r[1:0], 1'b0}, CFG_V.mode[0],
                CFG_V.ten_bit_packing_select);
    c_s  = samp(word_r, {idx_r[1:0], 1'b1}, CFG_V.mode[0],
                CFG_V.ten_bit_packing_select);
    c_f  = CFG_V.resample ?
           10'(({1'b0, c_s} + {1'b0, chist_r[1]}) >> 1) : c_s;
    lane = word_r[idx_r[0]*`VDT_LANE_W +: `VDT_LANE_W];
    if (raw && CFG_V.rgb_unpack_enable)
      pix_val = CFG_V.mode[0] ? lane[29:0] : {6'h00, lane[23:0]};
    else if (raw)
      pix_val = {20'h00000, samp(word_r, idx_r, CFG_V.mode[0],
                                 CFG_V.ten_bit_packing_select)};
    else
      pix_val = {10'h000, clip(y_s, CFG_V.y_lo, CFG_V.y_hi),
                 clip(c_f, CFG_V.c_lo, CFG_V.c_hi)};
  end

  // Chroma history for interpolation
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      chist_r[0] <= `VDT_BLANK_C;
      chist_r[1] <= `VDT_BLANK_C;
    end else if (take && !raw) begin
      chist_r[0] <= c_s;
      chist_r[1] <= chist_r[0];
    end
  end

  // Output pixel
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      vdata_r <= '0;
      img_r   <= 1'b0;
    end else if (adv) begin
      img_r <= take && !raw && !blank; // Image sample really shown
      if (blank)
        vdata_r <= {10'h000, `VDT_BLANK_Y, `VDT_BLANK_C};
      else if (take)
        vdata_r <= pix_val;
      else if (in_win && dup_r && st_r == ST_RUN)
        vdata_r <= vdata_r;
      else if (CFG_V.default_fill_enable)
        vdata_r <= {10'h000, CFG_V.y_def, 2'b00,
                    h_r[0] ? CFG_V.cr_def : CFG_V.cb_def, 2'b00};
      else
        vdata_r <= {10'h000, `VDT_BLANK_Y, `VDT_BLANK_C};
    end
  end
  assign VDATA = vdata_r;

  //------------------------------------------------------------------
  // DMA request
  //------------------------------------------------------------------
  wire push = DIN_VALID && DIN_READY;
  wire [4:0] avail = 5'(`VDT_DEPTH) - {1'b0, fcnt} - outst_r;
  wire go = THRESHOLD != 4'h0 && avail >= {1'b0, THRESHOLD};

  // One request per threshold of uncommitted space
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      req_r   <= 1'b0;
      outst_r <= '0;
    end else begin
      req_r   <= go;
      outst_r <= outst_r + (go ? {1'b0, THRESHOLD} : 5'h00)
                 - ((push && outst_r != 5'h00) ? 5'h01 : 5'h00);
    end
  end
  assign DMA_REQ = req_r;

  //------------------------------------------------------------------
  // Events
  //------------------------------------------------------------------
  always_comb begin
    ev.underrun = under;
    ev.complete = fdone && st_r == ST_RUN;
    ev.unacked  = ev.complete && pend_r;
    ev.vert1    = adv && !field_r && at(h_r, v_r, f.vs_x0, f.vs_y0);
    ev.vert2    = adv && field_r && at(h_r, v_r, f.vs_x0, f.vs_y0);
  end

  // Pending completion, set wins over acknowledge
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) pend_r <= 1'b0;
    else if (ev.complete) pend_r <= 1'b1;
    else if (CMP_ACK) pend_r <= 1'b0;
  end

  // Event pulses and masked interrupt
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ev_r  <= '0;
      int_r <= 1'b0;
    end else begin
      ev_r  <= ev;
      int_r <= |(ev & INT_MASK);
    end
  end
  assign EVENTS   = ev_r;
  assign INT_OUT  = int_r;
  assign FIELD_ID = field_r;

  //------------------------------------------------------------------
  // Assertions
  //------------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);

  AST_HSYNC_ON: assert property (
    adv && h_r == CFG_H.hs_start |=> hsync_r)
    else $error("hsync not set at start pixel");
  AST_HSYNC_OFF: assert property (
    adv && h_r == CFG_H.hs_stop && h_r != CFG_H.hs_start |=> !hsync_r)
    else $error("hsync not cleared at stop pixel");
  AST_HBLANK: assert property (
    adv && h_r == CFG_H.hb_start |=> hblank_r)
    else $error("hblank not set at start pixel");
  AST_WRAP: assert property (
    adv && h_end && !ext |=> h_r == 16'h0)
    else $error("pixel count did not wrap at frame width");
  AST_LINE: assert property (
    adv && h_end && !v_end && !ext |=> v_r == $past(v_r) + 16'h1)
    else $error("line count did not advance");
  AST_FIELD2: assert property (
    adv && field_r && at(h_r, v_r, CFG_F2.fld_x, CFG_F2.fld_y) |=> fld_r)
    else $error("field identity not raised");
  AST_PINS: assert property (
    ext |-> CTL_OE == 3'b000)
    else $error("pins driven under external timing");
  AST_CLIP: assert property (
    img_r |-> VDATA[19:10] >= {CFG_V.y_lo, 2'b00} &&
              VDATA[19:10] <= {CFG_V.y_hi, 2'b11})
    else $error("luma out of clip bounds");
  AST_FILL: assert property (
    adv && !blank && !in_win && CFG_V.default_fill_enable
    |=> VDATA[19:12] == $past(CFG_V.y_def))
    else $error("default luma missing outside window");
  AST_DMA: assert property (
    go |=> DMA_REQ && outst_r >= {1'b0, $past(THRESHOLD)})
    else $error("refill request missing or not booked");
  AST_INT: assert property (
    (ev & INT_MASK) != 5'h00 |=> INT_OUT && EVENTS == $past(ev))
    else $error("enabled event raised no interrupt");

  COV_UNDER:    cover property (st_r == ST_RUN ##1 st_r == ST_UND);
  COV_COMPLETE: cover property (ev.complete ##[1:1000] CMP_ACK);
  COV_FIELD:    cover property (fdone ##1 field_r);
endmodule

// >>> common/vdt_defs.svh
// Constants of the video display timing block
// Assumes inclusion ahead of the package and the design modules
`ifndef VDT_DEFS_SVH
`define VDT_DEFS_SVH
`define VDT_WORD_W   64
`define VDT_DEPTH    8
`define VDT_PIX_W    30
`define VDT_LANE_W   32
`define VDT_DENSE_W  10
`define VDT_NORM_W   16
`define VDT_BLANK_Y  10'h040
`define VDT_BLANK_C  10'h200
`define VDT_RST_CNT  16'h0000
`define VDT_RST_BIT  1'b0
`endif

// >>> common/vdt_pkg.sv
// Types of the video display timing block
// Assumes vdt_defs.svh is compiled with it
package vdt_pkg;
  typedef enum logic [1:0] {
    VDT_YC8 = 2'h0, VDT_YC10 = 2'h1, VDT_RAW8 = 2'h2, VDT_RAW10 = 2'h3
  } vdt_mode_t;
  typedef enum logic [1:0] {
    VDT_C1_HSYNC = 2'h0, VDT_C1_HBLANK = 2'h1,
    VDT_C1_ACTIVE = 2'h2, VDT_C1_FIELD = 2'h3
  } vdt_sel1_t;
  typedef enum logic [1:0] {
    VDT_C2_VSYNC = 2'h0, VDT_C2_VBLANK = 2'h1,
    VDT_C2_COMPOSITE = 2'h2, VDT_C2_FIELD = 2'h3
  } vdt_sel2_t;
  typedef enum logic {
    VDT_C3_COMPBLANK = 1'h0, VDT_C3_FIELD = 1'h1
  } vdt_sel3_t;
  typedef enum logic [2:0] {
    ST_WAIT = 3'b001, ST_RUN = 3'b010, ST_UND = 3'b100
  } vdt_state_t;
  typedef struct packed {
    logic [15:0] frame_width;
    logic [15:0] hb_start;
    logic [15:0] hb_stop;
    logic [15:0] hs_start;
    logic [15:0] hs_stop;
  } vdt_htim_t;
  typedef struct packed {
    logic [15:0] vb_x0, vb_y0, vb_x1, vb_y1;
    logic [15:0] vs_x0, vs_y0, vs_x1, vs_y1;
    logic [15:0] fld_x, fld_y;
    logic signed [15:0] img_hoff, img_voff;
    logic [15:0] img_w, img_h;
  } vdt_ftim_t;
  typedef struct packed {
    vdt_mode_t   mode;
    logic        ten_bit_packing_select;
    logic        scale;
    logic        resample;
    logic        default_fill_enable;
    logic        rgb_unpack_enable;
    logic        external_timing_enable;
    logic [3:0]  pixel_count_divider;
    logic [15:0] frame_height;
    logic [7:0]  y_lo, y_hi, c_lo, c_hi;
    logic [7:0]  y_def, cb_def, cr_def;
    vdt_sel1_t   sel1;
    vdt_sel2_t   sel2;
    vdt_sel3_t   sel3;
  } vdt_vid_t;
  typedef struct packed {
    logic underrun, complete, unacked, vert1, vert2;
  } vdt_evt_t;
endpackage

// >>> tb/vdt_enc_model.sv
// Encoder model on the far side of the display port
// Assumes the bench resolves pin levels from the port enables
`timescale 1ns/1ps
module vdt_enc_model (
  input  wire logic       ext,  // Slave mode on
  input  wire logic       field_identity_out,  // Field level to send
  output logic            vclk, // Link clock
  output logic [2:0]      ctl   // Pin drive
);
  logic [3:0] px_r = 4'h0;
  // Free-running pixel clock, 200 ns period
  initial begin
    vclk = 1'b0;
    #7;
    forever #100 vclk = ~vclk;
  end
  // Timing master in slave mode, toggling junk when released
  initial ctl = 3'h0;
  always @(posedge vclk) begin
    px_r <= px_r + 4'h1;
    ctl  <= ext ? {field_identity_out, 1'b0, px_r < 4'h3} : ~ctl;
  end
endmodule

// >>> tb/tb_top.sv
// Self-checking bench of the display timing block
// Assumes the encoder model and the design files compile first
`timescale 1ns/1ps
`include "vdt_defs.svh"
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  n_fail++; $display("[FAIL] %s exp %0d got %0d", n, e, g); end end
module tb_top
  import vdt_pkg::*;
;
  // ----------------------------------------
  // Wiring
  // ----------------------------------------
  logic        clk = 1'b0, arst_n = 1'b0, din_v = 1'b0, fld_cmd = 1'b0;
  logic        en = 1'b0, ack = 1'b0;
  logic [29:0] vd;
  logic [3:0]  thr = 4'h4;
  logic [4:0]  imask = 5'h00;
  logic [63:0] din = 64'h0;
  logic        vclk, dma, rdy, int_o, fid, stl;
  logic [2:0]  ctl_o, ctl_oe, enc_ctl, pins;
  vdt_vid_t    cv = '0;
  vdt_htim_t   ch = '0;
  vdt_ftim_t   cf = '0;
  vdt_evt_t    ev;
  int          n_fail = 0, samples_checked = 0, hi, per, acc, stop;
  int          cmp, una;
  // Pin level from both parties
  assign pins = (ctl_oe & ctl_o) | (~ctl_oe & enc_ctl);
  initial forever #12.5 clk = ~clk;
  vdt_top vdt_top_inst (.CLK(clk), .ARST_N(arst_n), .ENABLE(en),
    .UND_RECOVER(1'b0), .CMP_ACK(ack), .CFG_V(cv), .CFG_H(ch),
    .CFG_F1(cf), .CFG_F2(cf), .THRESHOLD(thr), .INT_MASK(imask),
    .VCLK_IN(vclk), .PIX_CLK_OUT(), .CTL_I(pins), .CTL_O(ctl_o),
    .CTL_OE(ctl_oe), .VDATA(vd), .DMA_REQ(dma), .DIN_VALID(din_v),
    .DIN(din), .DIN_READY(rdy), .EVENTS(ev), .INT_OUT(int_o),
    .FIELD_ID(fid), .STALLED(stl));
  vdt_enc_model vdt_enc_model_inst (.ext(cv.external_timing_enable),
    .field_identity_out(fld_cmd), .vclk(vclk), .ctl(enc_ctl));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task tick();
    @(posedge clk);
    #2;
  endtask
  function automatic logic pick(int w);
    return (w < 3) ? ctl_o[w] : fid;
  endfunction
  // Clocks from a start pixel to a stop pixel, eight per step
  function automatic int span(int a, int b, int fw);
    return ((b - a + fw) % fw) * 8;
  endfunction
  // High time and period of one watched signal
  task automatic meas(input int w);
    int t;
    t = 0;
    hi = 0;
    per = 0;
    while (pick(w) !== 1'b0 && t < 9000) begin tick(); t++; end
    while (pick(w) !== 1'b1 && t < 9000) begin tick(); t++; end
    while (pick(w) === 1'b1 && t < 9000) begin tick(); t++; hi++; end
    per = hi;
    while (pick(w) !== 1'b1 && t < 9000) begin tick(); t++; per++; end
  endtask
  task print_verdict();
    $display("checks %0d fails %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    n_fail++;
    print_verdict();
  end
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    cv.frame_height = 16'h0008;
    ch.frame_width = 16'h0010;
    ch.hb_start = 16'h000A;
    ch.hb_stop = 16'h0002;
    ch.hs_start = 16'h0002;
    ch.hs_stop = 16'h0005;
    cf.vs_y0 = 16'h0001;
    cf.vs_y1 = 16'h0003;
    // Vblank over line 0, window of four pixels on line 1
    cf.vb_y1 = 16'h0001;
    cf.img_w = 16'h0004;
    cf.img_h = 16'h0001;
    cv.default_fill_enable = 1'b1;
    void'($urandom(32'hF58D));
    // Default luma never equal to the blank level
    cv.y_def = 8'h80 | 8'($urandom);
    repeat (8) @(posedge clk);
    #2 arst_n = 1'b1;
    // Two refill requests: two thresholds fit in the empty buffer
    acc = 0;
    repeat (6) begin tick(); acc += dma; end
    `CHK("dma_req", 2, acc)
    `CHK("ctl_oe", 7, ctl_oe)
    // Random words until the buffer refuses
    acc = 0;
    repeat (12) begin
      din = {$urandom, $urandom};
      din_v = 1'b1;
      acc += rdy;
      tick();
    end
    din_v = 1'b0;
    // Eight stored words plus one in the working register
    `CHK("fifo_fill", 9, acc)
    `CHK("din_ready", 0, rdy)
    $display("test buffer done");
    // Line timing with a random sync stop
    stop = 3 + $urandom % 10;
    ch.hs_stop = stop[15:0];
    meas(0);
    `CHK("hsync_len", span(2, stop, 16), hi)
    `CHK("line_len", 128, per)
    cv.sel1 = VDT_C1_HBLANK;
    meas(0);
    `CHK("hblank_len", span(10, 2, 16), hi)
    meas(1);
    `CHK("vsync_len", 2 * 128, hi)
    `CHK("frame_len", 8 * 128, per)
    cv.sel3 = VDT_C3_FIELD;
    meas(2);
    `CHK("field_pin", 1024, hi)
    `CHK("field_period", 2048, per)
    meas(3);
    `CHK("field_id", 1024, hi)
    $display("test timing done");
    // Idle frame: 7 unblanked lines of 8 pixels, 8 clocks each
    acc = 0;
    repeat (1024) begin
      tick();
      acc += (vd[19:12] === cv.y_def);
    end
    `CHK("fill_cnt", 448, acc)
    // Run, acknowledge one completion, then watch two frames
    imask = 5'h0A;
    en = 1'b1;
    while (ev.complete !== 1'b1) tick();
    ack = 1'b1;
    tick();
    ack = 1'b0;
    acc = 0;
    hi = 0;
    per = 0;
    cmp = 0;
    una = 0;
    repeat (2048) begin
      tick();
      acc += int_o;
      hi += ev.vert1;
      per += ev.vert2;
      cmp += ev.complete;
      una += ev.unacked;
    end
    // Two completions and one field-one event are enabled
    `CHK("int_count", 3, acc)
    `CHK("vert1", 1, hi)
    `CHK("vert2", 1, per)
    `CHK("complete", 2, cmp)
    `CHK("unacked", 1, una)
    `CHK("stalled", 0, stl)
    $display("test events done");
    // Slave mode: pins become inputs
    cv.external_timing_enable = 1'b1;
    fld_cmd = 1'b1;
    repeat (300) tick();
    `CHK("oe_slave", 0, ctl_oe)
    `CHK("fid_slave", 1, fid)
    $display("test slave done");
    print_verdict();
  end
endmodule
